//--- src/apd_pkg.sv
/*
  Shared constants and types for the addressing mode postbyte decoder:
  prefix value, postbyte field positions, mode codes, states and the
  packed result record.
  Assumes a single core clock and a byte-wide instruction stream.
*/
package apd_pkg;

  // ----------------------------------------------------------------
  // stream constants
  // ----------------------------------------------------------------
  localparam logic [7:0] APD_PAGE2_PREFIX = 8'h18;
  localparam logic [7:0] APD_ZERO_PAGE_HI = 8'h00;

  // ----------------------------------------------------------------
  // postbyte field positions
  // ----------------------------------------------------------------
  localparam int APD_PB_RR_HI   = 7;   // base_register_select, short forms
  localparam int APD_PB_RR_LO   = 6;
  localparam int APD_PB_LONG_HI = 7;   // 111 marks the long forms
  localparam int APD_PB_LONG_LO = 5;
  localparam int APD_PB_RRL_HI  = 4;   // base_register_select, 111rr forms
  localparam int APD_PB_RRL_LO  = 3;
  localparam int APD_PB_FORM    = 5;   // 0: five-bit offset
  localparam int APD_PB_ACC     = 2;   // 1: accumulator offset
  localparam int APD_PB_Z       = 1;
  localparam int APD_PB_S       = 0;
  localparam int APD_PB_POST    = 4;   // p bit of auto adjust
  localparam int APD_PB_NEG     = 3;   // sign of auto adjust amount
  localparam logic [2:0] APD_PB_LONG_CODE = 3'h7;

  // base register codes
  localparam logic [1:0] APD_RR_X  = 2'h0;
  localparam logic [1:0] APD_RR_Y  = 2'h1;
  localparam logic [1:0] APD_RR_SP = 2'h2;
  localparam logic [1:0] APD_RR_PC = 2'h3;

  // accumulator_offset_select codes
  localparam logic [1:0] APD_AA_A    = 2'h0;
  localparam logic [1:0] APD_AA_B    = 2'h1;
  localparam logic [1:0] APD_AA_D    = 2'h2;
  localparam logic [1:0] APD_AA_DIND = 2'h3;

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    APD_MODE_REG_ONLY  = 3'h0,   // register_only_mode
    APD_MODE_INLINE    = 3'h1,   // inline_operand_mode
    APD_MODE_ZERO_PAGE = 3'h2,
    APD_MODE_LONG_ADDR = 3'h3,   // long_address_mode
    APD_MODE_BRANCH    = 3'h4,
    APD_MODE_INDEXED   = 3'h5    // indexed_short/nine/sixteen_bit modes
  } apd_mode_t;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    APD_ST_OPCODE = 6'h01,
    APD_ST_CLASS  = 6'h02,
    APD_ST_POST   = 6'h04,
    APD_ST_EXT    = 6'h08,
    APD_ST_CALC   = 6'h10,
    APD_ST_PTR    = 6'h20
  } apd_state_t;

  // classifier answer for one opcode
  typedef struct packed {
    apd_mode_t  mode;
    logic [1:0] ext_bytes;   // operand bytes after the opcode
  } apd_class_t;

  // decoded instruction handed to the core
  typedef struct packed {
    apd_mode_t   mode;
    logic        page2;
    logic [7:0]  opcode;
    logic [7:0]  index_postbyte;
    logic [15:0] eff_addr;
    logic [15:0] operand;
    logic        indirect;
    logic        adj_we;
    logic [1:0]  adj_sel;
    logic [15:0] adj_value;
    logic        illegal;
  } apd_result_t;

endpackage : apd_pkg

//--- src/apd_opcode_class.sv
/*
  Opcode classifier: maps an opcode and its page to an addressing mode
  and the number of operand bytes that follow; answer is registered.
  Assumes the caller waits one clock between offering an opcode and
  reading the answer.
*/
`timescale 1ns/100ps
`default_nettype none

module apd_opcode_class (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // query
  input  wire logic [7:0]        opcode_i,
  input  wire logic              page2_i,
  // answer
  output var  apd_pkg::apd_class_t class_o
);

  apd_pkg::apd_class_t nxt_class;
  apd_pkg::apd_class_t class_ff;

  // column decode by upper nibble; table is fixed, not software loaded
  always_comb begin
    nxt_class.mode      = apd_pkg::APD_MODE_REG_ONLY;
    nxt_class.ext_bytes = 2'h0;
    case (opcode_i[7:4])
      4'h2: begin
        nxt_class.mode      = apd_pkg::APD_MODE_BRANCH;
        nxt_class.ext_bytes = page2_i ? 2'h2 : 2'h1;
      end
      4'h8, 4'hC: begin
        nxt_class.mode = apd_pkg::APD_MODE_INLINE;
        // word-sized operations sit at low nibble 3 and at low nibbles C to F
        nxt_class.ext_bytes = (opcode_i[3:0] == 4'h3 ||
                               opcode_i[3:0] >= 4'hC) ? 2'h2 : 2'h1;
      end
      4'h9, 4'hD: begin
        nxt_class.mode      = apd_pkg::APD_MODE_ZERO_PAGE;
        nxt_class.ext_bytes = 2'h1;
      end
      4'hA, 4'hE: begin
        nxt_class.mode      = apd_pkg::APD_MODE_INDEXED;
        nxt_class.ext_bytes = 2'h0;
      end
      4'hB, 4'hF: begin
        nxt_class.mode      = apd_pkg::APD_MODE_LONG_ADDR;
        nxt_class.ext_bytes = 2'h2;
      end
      default: begin
        nxt_class.mode      = apd_pkg::APD_MODE_REG_ONLY;
        nxt_class.ext_bytes = 2'h0;
      end
    endcase
  end

  // registered answer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      class_ff <= '{mode: apd_pkg::APD_MODE_REG_ONLY, ext_bytes: 2'h0};
    end else begin
      class_ff <= nxt_class;
    end
  end

  assign class_o = class_ff;

endmodule : apd_opcode_class

`default_nettype wire

//--- src/apd_decoder.sv
/*
  Addressing mode and postbyte decoder. Takes bytes from the fetch
  queue, recognises the page-two prefix, classifies the opcode, reads
  the index_postbyte and extension bytes, forms the effective address
  and, for indirect forms, fetches the stored pointer.
  Assumes core registers are stable while an instruction is decoded
  and that memory answers a byte read with a one-cycle ack.
*/
`timescale 1ns/100ps
`default_nettype none

module apd_decoder (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  // instruction byte stream
  input  wire logic               byte_valid_i,
  input  wire logic [7:0]         byte_data_i,
  output var  logic               byte_ready_o,
  // core registers
  input  wire logic [15:0]        reg_x_i,
  input  wire logic [15:0]        reg_y_i,
  input  wire logic [15:0]        reg_sp_i,
  input  wire logic [15:0]        reg_pc_i,
  input  wire logic [7:0]         acc_a_i,
  input  wire logic [7:0]         acc_b_i,
  // pointer reads
  output var  logic               mem_req_o,
  output var  logic [15:0]        mem_addr_o,
  input  wire logic               mem_ack_i,
  input  wire logic [7:0]         mem_rdata_i,
  // decoded result
  output var  logic               done_o,
  output var  apd_pkg::apd_result_t result_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // base register pick, used by every indexed form
  function automatic logic [15:0] pick_base(input logic [1:0] sel,
                                            input logic [15:0] x,
                                            input logic [15:0] y,
                                            input logic [15:0] sp,
                                            input logic [15:0] pc);
    case (sel)
      apd_pkg::APD_RR_X:  pick_base = x;
      apd_pkg::APD_RR_Y:  pick_base = y;
      apd_pkg::APD_RR_SP: pick_base = sp;
      default:            pick_base = pc;
    endcase
  endfunction : pick_base

  // count of extension bytes a postbyte asks for
  function automatic logic [1:0] ext_count(input logic [7:0] pb);
    if (!pb[apd_pkg::APD_PB_FORM]) begin
      ext_count = 2'h0;
    end else if (pb[apd_pkg::APD_PB_LONG_HI:apd_pkg::APD_PB_LONG_LO]
                 != apd_pkg::APD_PB_LONG_CODE) begin
      ext_count = 2'h0;
    end else if (pb[apd_pkg::APD_PB_ACC]) begin
      ext_count = 2'h0;
    end else begin
      ext_count = pb[apd_pkg::APD_PB_Z] ? 2'h2 : 2'h1;
    end
  endfunction : ext_count

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  apd_pkg::apd_state_t  state_ff;
  apd_pkg::apd_state_t  nxt_state;
  apd_pkg::apd_class_t  class_w;
  logic                 page2_ff;
  logic [7:0]           opcode_ff;
  logic [7:0]           postbyte_ff;
  logic [15:0]          ext_ff;
  logic [1:0]           ext_left_ff;
  logic                 ptr_lo_ff;
  logic [7:0]           ptr_hi_ff;
  logic                 byte_ready_ff;
  logic                 mem_req_ff;
  logic [15:0]          mem_addr_ff;
  logic                 done_ff;
  apd_pkg::apd_result_t result_ff;
  apd_pkg::apd_result_t nxt_result;
  logic                 take;
  logic [7:0]           class_op_w;

  assign take = byte_valid_i && byte_ready_ff;
  // classify the byte as it is taken: the answer is registered, so
  // feeding opcode_ff would leave a stale class in CLASS
  assign class_op_w = (state_ff == apd_pkg::APD_ST_OPCODE) ?
                      byte_data_i : opcode_ff;

  apd_opcode_class u_class (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .opcode_i  (class_op_w),
    .page2_i   (page2_ff),
    .class_o   (class_w)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      apd_pkg::APD_ST_OPCODE: begin
        // prefix stays here for second byte
        if (take && !(byte_data_i == apd_pkg::APD_PAGE2_PREFIX
                      && !page2_ff)) begin
          nxt_state = apd_pkg::APD_ST_CLASS;
        end
      end
      apd_pkg::APD_ST_CLASS: begin
        if (class_w.mode == apd_pkg::APD_MODE_INDEXED) begin
          nxt_state = apd_pkg::APD_ST_POST;
        end else if (class_w.ext_bytes == 2'h0) begin
          nxt_state = apd_pkg::APD_ST_CALC;
        end else begin
          nxt_state = apd_pkg::APD_ST_EXT;
        end
      end
      apd_pkg::APD_ST_POST: begin
        if (take) begin
          nxt_state = (ext_count(byte_data_i) == 2'h0) ?
                      apd_pkg::APD_ST_CALC : apd_pkg::APD_ST_EXT;
        end
      end
      apd_pkg::APD_ST_EXT: begin
        if (take && ext_left_ff == 2'h1) begin
          nxt_state = apd_pkg::APD_ST_CALC;
        end
      end
      apd_pkg::APD_ST_CALC: begin
        nxt_state = nxt_result.indirect ? apd_pkg::APD_ST_PTR :
                                          apd_pkg::APD_ST_OPCODE;
      end
      apd_pkg::APD_ST_PTR: begin
        if (mem_ack_i && ptr_lo_ff) begin
          nxt_state = apd_pkg::APD_ST_OPCODE;
        end
      end
      default: nxt_state = apd_pkg::APD_ST_OPCODE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= apd_pkg::APD_ST_OPCODE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ready follows the byte-consuming states
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      byte_ready_ff <= 1'b0;
    end else begin
      byte_ready_ff <= (nxt_state == apd_pkg::APD_ST_OPCODE) ||
                       (nxt_state == apd_pkg::APD_ST_POST) ||
                       (nxt_state == apd_pkg::APD_ST_EXT);
    end
  end

  // ----------------------------------------------------------------
  // byte capture
  // ----------------------------------------------------------------

  // opcode and page flag
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      page2_ff  <= 1'b0;
      opcode_ff <= 8'h00;
    end else if (state_ff == apd_pkg::APD_ST_OPCODE && take) begin
      // prefix marks the second opcode map
      if (byte_data_i == apd_pkg::APD_PAGE2_PREFIX && !page2_ff) begin
        page2_ff <= 1'b1;
      end else begin
        opcode_ff <= byte_data_i;
      end
    end else if (state_ff == apd_pkg::APD_ST_CALC) begin
      page2_ff <= 1'b0;   // cleared once the record is formed
    end
  end

  // postbyte and extension bytes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      postbyte_ff <= 8'h00;
      ext_ff      <= 16'h0000;
      ext_left_ff <= 2'h0;
    end else begin
      case (state_ff)
        apd_pkg::APD_ST_CLASS: begin
          // inline, zero page, long and branch operand count
          ext_left_ff <= class_w.ext_bytes;
          ext_ff      <= 16'h0000;
          postbyte_ff <= 8'h00;
        end
        apd_pkg::APD_ST_POST: begin
          if (take) begin
            postbyte_ff <= byte_data_i;
            ext_left_ff <= ext_count(byte_data_i);
          end
        end
        apd_pkg::APD_ST_EXT: begin
          // first of two bytes shifts up to the high half; a lone byte stays low
          if (take) begin
            ext_ff      <= {ext_ff[7:0], byte_data_i};
            ext_left_ff <= ext_left_ff - 2'h1;
          end
        end
        default: begin
          ext_left_ff <= ext_left_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  logic [15:0] base_w;
  logic [15:0] acc_d_w;
  logic [15:0] adj_delta_w;
  logic [15:0] adj_new_w;
  logic [1:0]  rr_short_w;
  logic [1:0]  rr_long_w;
  logic        long_form_w;

  assign rr_short_w  = postbyte_ff[apd_pkg::APD_PB_RR_HI:
                                   apd_pkg::APD_PB_RR_LO];
  assign rr_long_w   = postbyte_ff[apd_pkg::APD_PB_RRL_HI:
                                   apd_pkg::APD_PB_RRL_LO];
  assign long_form_w = postbyte_ff[apd_pkg::APD_PB_LONG_HI:
                                   apd_pkg::APD_PB_LONG_LO]
                       == apd_pkg::APD_PB_LONG_CODE;
  assign base_w      = pick_base(long_form_w ? rr_long_w : rr_short_w,
                                 reg_x_i, reg_y_i, reg_sp_i, reg_pc_i);
  // D from A high and B low
  assign acc_d_w     = {acc_a_i, acc_b_i};
  // amount 1..8 up or -8..-1 down
  assign adj_delta_w = postbyte_ff[apd_pkg::APD_PB_NEG] ?
                       {12'hFFF, postbyte_ff[3:0]} :
                       {12'h000, postbyte_ff[3:0]} + 16'h0001;
  assign adj_new_w   = base_w + adj_delta_w;

  // result record for the current instruction
  always_comb begin
    nxt_result                = '0;
    nxt_result.mode           = class_w.mode;
    nxt_result.page2          = page2_ff;
    nxt_result.opcode         = opcode_ff;
    nxt_result.index_postbyte = postbyte_ff;
    case (class_w.mode)
      apd_pkg::APD_MODE_INLINE: begin
        nxt_result.operand = ext_ff;
      end
      apd_pkg::APD_MODE_ZERO_PAGE: begin
        nxt_result.eff_addr = {apd_pkg::APD_ZERO_PAGE_HI, ext_ff[7:0]};
      end
      apd_pkg::APD_MODE_LONG_ADDR: begin
        nxt_result.eff_addr = ext_ff;
      end
      apd_pkg::APD_MODE_BRANCH: begin
        // short offset sign extended onto pc
        nxt_result.operand  = ext_ff;
        nxt_result.eff_addr = page2_ff ? reg_pc_i + ext_ff :
                              reg_pc_i + {{8{ext_ff[7]}}, ext_ff[7:0]};
      end
      apd_pkg::APD_MODE_INDEXED: begin
        if (!postbyte_ff[apd_pkg::APD_PB_FORM]) begin
          // sign extended, wraps at sixteen bits
          nxt_result.eff_addr = base_w +
                                {{11{postbyte_ff[4]}}, postbyte_ff[4:0]};
        end else if (!long_form_w) begin
          // pc base cannot be auto adjusted
          nxt_result.illegal   = (rr_short_w == apd_pkg::APD_RR_PC);
          // pre uses new value, post uses old
          nxt_result.adj_we    = (rr_short_w != apd_pkg::APD_RR_PC);
          nxt_result.adj_sel   = rr_short_w;
          nxt_result.adj_value = adj_new_w;
          nxt_result.eff_addr  = postbyte_ff[apd_pkg::APD_PB_POST] ?
                                 base_w : adj_new_w;
        end else if (!postbyte_ff[apd_pkg::APD_PB_ACC]) begin
          if (!postbyte_ff[apd_pkg::APD_PB_Z]) begin
            nxt_result.eff_addr = base_w +
              {{8{postbyte_ff[apd_pkg::APD_PB_S]}}, ext_ff[7:0]};
          end else begin
            nxt_result.eff_addr = base_w + ext_ff;
            nxt_result.indirect = postbyte_ff[apd_pkg::APD_PB_S];
          end
        end else begin
          case (postbyte_ff[1:0])
            apd_pkg::APD_AA_A: nxt_result.eff_addr = base_w +
                                                     {8'h00, acc_a_i};
            apd_pkg::APD_AA_B: nxt_result.eff_addr = base_w +
                                                     {8'h00, acc_b_i};
            default:           nxt_result.eff_addr = base_w + acc_d_w;
          endcase
          nxt_result.indirect = (postbyte_ff[1:0] ==
                                 apd_pkg::APD_AA_DIND);
        end
      end
      default: begin
        nxt_result.eff_addr = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pointer fetch and result
  // ----------------------------------------------------------------

  // read pointer high then low byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mem_req_ff  <= 1'b0;
      mem_addr_ff <= 16'h0000;
      ptr_lo_ff   <= 1'b0;
      ptr_hi_ff   <= 8'h00;
    end else if (state_ff == apd_pkg::APD_ST_CALC &&
                 nxt_result.indirect) begin
      mem_req_ff  <= 1'b1;
      mem_addr_ff <= nxt_result.eff_addr;
      ptr_lo_ff   <= 1'b0;
    end else if (state_ff == apd_pkg::APD_ST_PTR && mem_ack_i) begin
      // second byte at next address, no alignment
      if (!ptr_lo_ff) begin
        ptr_hi_ff   <= mem_rdata_i;
        mem_addr_ff <= mem_addr_ff + 16'h0001;
        ptr_lo_ff   <= 1'b1;
      end else begin
        mem_req_ff <= 1'b0;
        ptr_lo_ff  <= 1'b0;
      end
    end
  end

  // result register and completion pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      result_ff <= '0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == apd_pkg::APD_ST_CALC) begin
        result_ff <= nxt_result;
        done_ff   <= !nxt_result.indirect;
      end else if (state_ff == apd_pkg::APD_ST_PTR && mem_ack_i &&
                   ptr_lo_ff) begin
        result_ff.eff_addr <= {ptr_hi_ff, mem_rdata_i};
        done_ff            <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign byte_ready_o = byte_ready_ff;
  assign mem_req_o    = mem_req_ff;
  assign mem_addr_o   = mem_addr_ff;
  assign done_o       = done_ff;
  assign result_o     = result_ff;

endmodule : apd_decoder

`default_nettype wire

//--- dv/apd_mem_model.sv
/*
  Memory partner for the decoder's pointer reads.
  Assumes one clock; answers each byte request after lat_i idle cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module apd_mem_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // request side
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [1:0]  lat_i,
  // answer side
  output var  logic        ack_o,
  output var  logic [7:0]  rdata_o
);
  logic [1:0] cnt_ff;

  // one-cycle ack; read data toggles outside the ack so no stale byte
  // can pass for a real answer
  always_ff @(posedge clk_sys_i) begin
    ack_o   <= 1'b0;
    rdata_o <= rst_i ? 8'h3C : ~rdata_o;
    if (rst_i || !req_i || ack_o) begin
      cnt_ff <= 2'h0;
    end else if (cnt_ff == lat_i) begin
      ack_o   <= 1'b1;
      rdata_o <= addr_i[7:0] ^ 8'hA5;  // stored byte pattern
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule : apd_mem_model

`default_nettype wire

//--- dv/apd_decoder_monitor.sv
/*
  Port checker for the decoder.
  Assumes it is bound to apd_decoder and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module apd_decoder_monitor (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic                byte_ready_o,
  input wire logic                mem_req_o,
  input wire logic [15:0]         mem_addr_o,
  input wire logic                mem_ack_i,
  input wire logic                done_o,
  input wire apd_pkg::apd_result_t result_o,
  input wire logic [15:0]         reg_x_i,
  input wire logic [15:0]         reg_y_i,
  input wire logic [15:0]         reg_sp_i,
  input wire logic [15:0]         reg_pc_i,
  input wire logic [7:0]          acc_a_i,
  input wire logic [7:0]          acc_b_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic [7:0]  pb;
  logic [15:0] acc_off;
  logic        idx;
  // base register picked by a two-bit select
  function automatic logic [15:0] bsel(input logic [1:0] r);
    return r == 2'h0 ? reg_x_i : r == 2'h1 ? reg_y_i :
           r == 2'h2 ? reg_sp_i : reg_pc_i;
  endfunction : bsel
  assign pb = result_o.index_postbyte;
  assign idx = done_o && result_o.mode == apd_pkg::APD_MODE_INDEXED;
  assign acc_off = pb[1:0] == 2'h0 ? {8'h00, acc_a_i} :
                   pb[1:0] == 2'h1 ? {8'h00, acc_b_i} : {acc_a_i, acc_b_i};

  // pointer read: an ack, then the request released
  sequence s_ack;
    mem_req_o && mem_ack_i;
  endsequence
  sequence s_ptr_end;
    s_ack ##1 !mem_req_o;
  endsequence

  property p_zpage;
    done_o && result_o.mode == apd_pkg::APD_MODE_ZERO_PAGE
      |-> result_o.eff_addr[15:8] == apd_pkg::APD_ZERO_PAGE_HI;
  endproperty
  a_zpage: assert property (p_zpage) else $error("zero page high");
  property p_short;
    idx && !pb[5] && pb[7:6] != apd_pkg::APD_RR_PC
      |-> result_o.eff_addr == bsel(pb[7:6]) + {{11{pb[4]}}, pb[4:0]};
  endproperty
  a_short: assert property (p_short) else $error("short offset");
  property p_acc;
    idx && pb[7:5] == 3'h7 && pb[2] && pb[1:0] != 2'h3 && pb[4:3] != 2'h3
      |-> result_o.eff_addr == bsel(pb[4:3]) + acc_off;
  endproperty
  a_acc: assert property (p_acc) else $error("acc offset");
  property p_adj;
    done_o && result_o.adj_we |-> result_o.adj_value -
      bsel(result_o.adj_sel) inside {[16'h1:16'h8], [16'hFFF8:16'hFFFF]};
  endproperty
  a_adj: assert property (p_adj) else $error("adjust amount");
  property p_pc_adj;
    done_o && result_o.adj_we |-> result_o.adj_sel != apd_pkg::APD_RR_PC;
  endproperty
  a_pc_adj: assert property (p_pc_adj) else $error("pc adjusted");
  property p_busy;
    mem_req_o |-> !byte_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("stream open");
  property p_bump;
    s_ack |=> !mem_req_o || mem_addr_o == $past(mem_addr_o) + 16'h1;
  endproperty
  a_bump: assert property (p_bump) else $error("pointer addr");
  property p_ptr_done;
    s_ptr_end |-> ##[0:1] done_o && result_o.indirect;
  endproperty
  a_ptr_done: assert property (p_ptr_done) else $error("no record");
  property p_ind;
    done_o && result_o.indirect |-> pb[7:5] == 3'h7 && pb[1:0] == 2'h3;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect form");
endmodule : apd_decoder_monitor

`default_nettype wire

//--- dv/tb.sv
/*
  Self-checking bench for the decoder with a memory partner.
  Assumes inputs change at the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        byte_valid_i = 1'b0;
  logic [7:0]  byte_data_i = 8'h00;
  logic [15:0] reg_x_i = 16'h1000;
  logic [15:0] reg_y_i = 16'h2000;
  logic [15:0] reg_sp_i = 16'h3000;
  logic [15:0] reg_pc_i = 16'h4000;
  logic [7:0]  acc_a_i = 8'h81;
  logic [7:0]  acc_b_i = 8'h02;
  logic [1:0]  lat = 2'h0;
  logic        byte_ready_o, mem_req_o, mem_ack_i, done_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_rdata_i;
  apd_pkg::apd_result_t result_o;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;
  apd_decoder i_dut (.clk_sys_i, .rst_i, .byte_valid_i, .byte_data_i,
    .byte_ready_o, .reg_x_i, .reg_y_i, .reg_sp_i, .reg_pc_i, .acc_a_i,
    .acc_b_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i, .done_o,
    .result_o);
  apd_mem_model i_mem (.clk_sys_i, .rst_i, .req_i(mem_req_o),
    .addr_i(mem_addr_o), .lat_i(lat), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // feed n bytes, high byte of b first, then wait for the record
  task automatic run(logic [31:0] b, int n, logic [2:0] m, bit ce,
                     logic [15:0] ea);
    int k;
    for (int i = 0; i < n; i++) begin
      byte_data_i = b[31-8*i -: 8];
      byte_valid_i = 1'b1;
      // ready is registered: its value at the falling edge is the one
      // that the next rising edge samples
      while (byte_ready_o !== 1'b1) @(negedge clk_sys_i);
      @(negedge clk_sys_i);
    end
    byte_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 50) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("done", 16'h0001, {15'h0000, done_o});
    chk("mode", {13'h0000, m}, {13'h0000, result_o.mode});
    if (ce) chk("eff_addr", ea, result_o.eff_addr);
  endtask : run
  task automatic idx(logic [31:0] b, int n, logic [15:0] ea);
    run(b, n, apd_pkg::APD_MODE_INDEXED, 1'b1, ea);
  endtask : idx

  task automatic t_plain;
    run(32'hB6123400, 3, apd_pkg::APD_MODE_LONG_ADDR, 1, 16'h1234);
    run(32'h01000000, 1, apd_pkg::APD_MODE_REG_ONLY, 0, 16'h0);
    run(32'h96800000, 2, apd_pkg::APD_MODE_ZERO_PAGE, 1, 16'h80);
    run(32'h20800000, 2, apd_pkg::APD_MODE_BRANCH, 1, 16'h3F80);
    run(32'h1820FFFE, 4, apd_pkg::APD_MODE_BRANCH, 1, 16'h3FFE);
    chk("page2", 16'h0001, {15'h0000, result_o.page2});
    run(32'h86550000, 2, apd_pkg::APD_MODE_INLINE, 0, 16'h0);
    chk("operand", 16'h0055, result_o.operand);
    run(32'h8C123400, 3, apd_pkg::APD_MODE_INLINE, 0, 16'h0);
    chk("operand", 16'h1234, result_o.operand);
    chk("opcode", 16'h008C, {8'h00, result_o.opcode});
    $display("t_plain done");
  endtask : t_plain
  task automatic t_indexed;
    idx(32'hA61F0000, 2, 16'h0FFF);
    idx(32'hA64F0000, 2, 16'h200F);
    idx(32'hA6E98000, 3, 16'h1F80);
    idx(32'hA6F28000, 4, 16'hB000);
    idx(32'hA6E40000, 2, 16'h1081);
    idx(32'hA6ED0000, 2, 16'h2002);
    idx(32'hA6F60000, 2, 16'hB102);
    $display("t_indexed done");
  endtask : t_indexed
  task automatic t_auto;
    idx(32'hA63F0000, 2, 16'h1000);
    chk("adj_value", 16'h0FFF, result_o.adj_value);
    idx(32'hA6670000, 2, 16'h2008);
    chk("adj_value", 16'h2008, result_o.adj_value);
    chk("adj_sel", 16'h0001, {14'h0000, result_o.adj_sel});
    chk("adj_we", 16'h0001, {15'h0000, result_o.adj_we});
    $display("t_auto done");
  endtask : t_auto
  // slow then prompt pointer answers
  task automatic t_indirect;
    lat = 2'h3;
    idx(32'hA6F30010, 4, 16'hB5B4);
    lat = 2'h0;
    idx(32'hA6E70000, 2, 16'hA7A6);
    chk("indirect", 16'h0001, {15'h0000, result_o.indirect});
    $display("t_indirect done");
  endtask : t_indirect

  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_plain();
    t_indexed();
    t_auto();
    t_indirect();
    complete_run();
  end
endmodule : tb

bind apd_decoder apd_decoder_monitor i_mon (.clk_sys_i, .rst_i,
  .byte_ready_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .done_o, .result_o,
  .reg_x_i, .reg_y_i, .reg_sp_i, .reg_pc_i, .acc_a_i, .acc_b_i);

`default_nettype wire
